// ### nvm_prog_pkg.sv
// Shared constants of the parallel nonvolatile programming port
package nvm_prog_pkg;
  // Command bytes
  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] CMD_ERASE = 8'h80;
  localparam logic [7:0] CMD_FUSE_WR = 8'h40;
  localparam logic [7:0] CMD_LOCK_WR = 8'h20;
  localparam logic [7:0] CMD_FLASH_WR = 8'h10;
  localparam logic [7:0] CMD_EE_WR = 8'h11;
  localparam logic [7:0] CMD_FLASH_RD = 8'h02;
  localparam logic [7:0] CMD_EE_RD = 8'h03;
  // Action-select codes
  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD = 2'h2;
  localparam logic [1:0] ACT_IDLE = 2'h3;
  // Memory geometry
  localparam int FLASH_WORDS = 8192;
  localparam int EE_BYTES = 512;
  localparam int PAGE_WORDS = 64;
  localparam logic [12:0] FLASH_LAST = 13'h1FFF;
  localparam logic [5:0] PAGE_LAST = 6'h3F;
  // Nonvolatile bits: reset values and bits forced to one
  localparam logic [7:0] FUSE_LO_RESET = 8'hD2;
  localparam logic [7:0] FUSE_HI_RESET = 8'hFF;
  localparam logic [7:0] LOCK_RESET = 8'hFF;
  localparam logic [7:0] FUSE_LO_KEEP = 8'h10;
  localparam logic [7:0] FUSE_HI_KEEP = 8'hF8;
  localparam logic [7:0] LOCK_KEEP = 8'hC0;
  localparam logic [15:0] WORD_ERASED = 16'hFFFF;
  localparam logic [7:0] BYTE_ERASED = 8'hFF;
  // Timing
  localparam int CLK_MHZ = 25;
  localparam int T_ENTRY_NS = 100;
  localparam int T_PULSE_NS = 500;
  localparam int T_BYTE_US = 1500;
  localparam int T_PAGE_US = 12000;
  localparam int T_ERASE_US = 23000;
  localparam logic [1:0] ENTRY_CYC =
    2'((T_ENTRY_NS * CLK_MHZ + 999) / 1000);
  localparam logic [3:0] PULSE_CYC =
    4'((T_PULSE_NS * CLK_MHZ + 999) / 1000);
  localparam int BYTE_CYC = T_BYTE_US * CLK_MHZ;
  localparam int PAGE_CYC = T_PAGE_US * CLK_MHZ;
  localparam int ERASE_CYC = T_ERASE_US * CLK_MHZ;
  // Host register offsets and fields
  localparam logic [3:0] REG_OP = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_RDATA = 4'h2;
  localparam int OP_CODE_LSB = 0;
  localparam int OP_ACT_LSB = 4;
  localparam int OP_BS_BIT = 6;
  localparam int OP_DATA_LSB = 8;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_READY_BIT = 1;
  localparam int ST_MODE_BIT = 2;
  // Host operation codes
  localparam logic [2:0] OP_LOAD = 3'h0;
  localparam logic [2:0] OP_LATCH = 3'h1;
  localparam logic [2:0] OP_PROG = 3'h2;
  localparam logic [2:0] OP_READ = 3'h3;
  localparam logic [2:0] OP_ENTER = 3'h4;
  localparam logic [2:0] OP_EXIT = 3'h5;
endpackage

// ### nvm_prog_if.sv
// Pin bundle between the programmer and the programmed device
`timescale 1ns/100ps
interface nvm_prog_if;
  logic action_sel_1;
  logic action_sel_0;
  logic byte_sel_lo_hi;
  logic byte_sel_ext;
  logic buffer_latch_pulse;
  logic load_strobe_pin;
  logic prog_strobe_n;
  logic out_enable_n;
  logic prog_voltage;
  logic [7:0] host_data;
  logic host_data_oe;
  logic [7:0] dev_data;
  logic dev_data_oe;
  logic ready_busy_flag;
  logic [7:0] data_bus;

  // Resolved bus level; an undriven bus floats high
  assign data_bus = dev_data_oe ? dev_data :
                    host_data_oe ? host_data : 8'hFF;

  modport device (
    input action_sel_1, action_sel_0, byte_sel_lo_hi, byte_sel_ext,
    input buffer_latch_pulse, load_strobe_pin, prog_strobe_n,
    input out_enable_n, prog_voltage, data_bus,
    output dev_data, dev_data_oe, ready_busy_flag
  );

  modport host (
    output action_sel_1, action_sel_0, byte_sel_lo_hi, byte_sel_ext,
    output buffer_latch_pulse, load_strobe_pin, prog_strobe_n,
    output out_enable_n, prog_voltage, host_data, host_data_oe,
    input ready_busy_flag, data_bus
  );
endinterface

// ### nvm_prog_device.sv
// Device end: command decoder, page buffer and nonvolatile arrays
`timescale 1ns/100ps
// How it works
// [RULE1] Load strobe acts per action-select code
// [RULE2] Erase command plus write strobe erases chip
// [RULE3] Erase clears arrays, locks released last
// [RULE4] Programmer erases first, waits for ready
// [RULE5] Flash pages filled via page buffer
// [RULE6] Flash write starts by command byte load
// [RULE7] Address load picks low/high by byte select
// [RULE8] Latch pulse stores data byte lane
// [RULE9] Programmer repeats word fill 64 times
// [RULE10] Page number from high and low address
// [RULE11] Write strobe programs page, busy meanwhile
// [RULE12] No-operation command ends page writing
// [RULE13] EEPROM byte written on write strobe
// [RULE14] Command and address kept across accesses
// [RULE15] Flash read drives selected word byte
// [RULE16] EEPROM read drives addressed byte
// [RULE17] Low fuse write, bit four forced one
// [RULE18] High fuse write, upper bits forced one
// [RULE19] Lock write programs zero bits only
// [RULE20] Only chip erase unprograms lock bits
// [RULE21] Byte selects low and steady around entry
// [RULE22] Ready flag low while operation runs
// [RULE23] Device drives data only when enabled
// [RULE24] Strobes ignored while device is busy
module nvm_prog_device #(
  parameter int ERASE_CYC = nvm_prog_pkg::ERASE_CYC,
  parameter int PAGE_CYC = nvm_prog_pkg::PAGE_CYC,
  parameter int BYTE_CYC = nvm_prog_pkg::BYTE_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Programming pins
  nvm_prog_if.device pins,
  // Nonvolatile bit state and programming-mode flag seen by the rest of the chip
  output logic [7:0] fuse_lo,
  output logic [7:0] fuse_hi,
  output logic [7:0] lock_bits,
  output logic prog_mode_active
);
  typedef enum logic [3:0] {
    D_IDLE = 4'h1,
    D_ERASE = 4'h2,
    D_PAGE = 4'h4,
    D_BYTE = 4'h8
  } dev_state_e;
  typedef struct packed {
    dev_state_e state;
    logic in_mode;
    logic [1:0] entry_cnt;
    logic prev_load, prev_latch, prev_wr_n, prev_mode;
    logic [7:0] cmd, addr_lo, addr_hi, data, fuse_lo, fuse_hi, lock;
    logic [31:0] timer;
    logic [12:0] idx;
    logic sweep_done, rdy;
    logic [7:0] dout;
    logic doe;
  } dev_s;
  dev_s cur, next_cur;
  // Arrays live outside the state struct; they are memories, not flops
  logic [15:0] flash_mem [nvm_prog_pkg::FLASH_WORDS];
  logic [7:0] ee_mem [nvm_prog_pkg::EE_BYTES];
  logic [15:0] page_buf [nvm_prog_pkg::PAGE_WORDS];
  logic load_rise, latch_rise, wr_fall, accept, bs_any, fl_we, ee_we, pb_we;
  logic [12:0] rd_waddr, fl_waddr, pg_waddr;
  logic [8:0] ee_addr, ee_waddr;
  logic [15:0] fl_wdata, pb_wdata;
  logic [7:0] ee_wdata;
  logic [5:0] pb_idx;
  // Seven-bit page number from both address bytes
  function automatic logic [6:0] page_of(input logic [7:0] hi,
                                         input logic [7:0] lo);
    page_of = {hi[4:0], lo[7:6]}; // [RULE10]
  endfunction
  // Pins are synchronous; edges come from the previous sample
  assign load_rise = pins.load_strobe_pin & ~cur.prev_load;
  assign latch_rise = pins.buffer_latch_pulse & ~cur.prev_latch;
  assign wr_fall = ~pins.prog_strobe_n & cur.prev_wr_n;
  assign bs_any = pins.byte_sel_lo_hi | pins.byte_sel_ext;
  // Nothing is taken during entry settling or while busy
  assign accept = cur.in_mode && (cur.entry_cnt == 2'h0) &&
                  (cur.state == D_IDLE); // [RULE24]
  assign rd_waddr = {page_of(cur.addr_hi, cur.addr_lo), cur.addr_lo[5:0]};
  assign ee_addr = {cur.addr_hi[0], cur.addr_lo};
  assign pg_waddr = {page_of(cur.addr_hi, cur.addr_lo), cur.idx[5:0]};
  // Next-state logic
  always_comb begin
    next_cur = cur;
    fl_we = 1'b0;
    fl_waddr = cur.idx;
    fl_wdata = nvm_prog_pkg::WORD_ERASED;
    ee_we = 1'b0;
    ee_waddr = ee_addr;
    ee_wdata = nvm_prog_pkg::BYTE_ERASED;
    pb_we = 1'b0;
    pb_idx = cur.addr_lo[5:0];
    pb_wdata = page_buf[cur.addr_lo[5:0]];
    next_cur.prev_load = pins.load_strobe_pin;
    next_cur.prev_latch = pins.buffer_latch_pulse;
    next_cur.prev_wr_n = pins.prog_strobe_n;
    next_cur.prev_mode = pins.prog_voltage;
    // Mode entry: byte selects must stay low while the level settles;
    // a failed entry stays off until the level drops again
    if (!pins.prog_voltage) begin
      next_cur.in_mode = 1'b0;
      next_cur.entry_cnt = 2'h0;
    end else if (!cur.prev_mode) begin
      if (!bs_any) begin
        next_cur.in_mode = 1'b1; // [RULE21]
        next_cur.entry_cnt = nvm_prog_pkg::ENTRY_CYC;
      end
    end else if (cur.entry_cnt != 2'h0) begin
      next_cur.entry_cnt = cur.entry_cnt - 2'h1;
      if (bs_any) begin
        next_cur.in_mode = 1'b0; // [RULE21]
      end
    end
    case (cur.state)
      D_IDLE: begin
        if (accept && load_rise) begin
          // Loaded values persist until reloaded [RULE14]
          case ({pins.action_sel_1, pins.action_sel_0}) // [RULE1]
            nvm_prog_pkg::ACT_ADDR: begin
              if (pins.byte_sel_lo_hi) begin
                next_cur.addr_hi = pins.data_bus; // [RULE7]
              end else begin
                next_cur.addr_lo = pins.data_bus; // [RULE7]
              end
            end
            nvm_prog_pkg::ACT_DATA: next_cur.data = pins.data_bus;
            // A no-operation byte disables every write action [RULE12]
            nvm_prog_pkg::ACT_CMD: next_cur.cmd = pins.data_bus;
            default: next_cur.cmd = cur.cmd;
          endcase
        end
        if (accept && latch_rise &&
            cur.cmd == nvm_prog_pkg::CMD_FLASH_WR) begin
          pb_we = 1'b1; // [RULE8]
          if (pins.byte_sel_lo_hi) begin
            pb_wdata = {cur.data, page_buf[pb_idx][7:0]};
          end else begin
            pb_wdata = {page_buf[pb_idx][15:8], cur.data};
          end
        end
        if (accept && wr_fall) begin
          next_cur.idx = 13'h0000;
          next_cur.sweep_done = 1'b1;
          next_cur.timer = 32'(BYTE_CYC - 1);
          case (cur.cmd)
            nvm_prog_pkg::CMD_ERASE: begin
              next_cur.state = D_ERASE; // [RULE2]
              next_cur.sweep_done = 1'b0;
              next_cur.timer = 32'(ERASE_CYC - 1);
            end
            nvm_prog_pkg::CMD_FLASH_WR: begin
              next_cur.state = D_PAGE; // [RULE11]
              next_cur.sweep_done = 1'b0;
              next_cur.timer = 32'(PAGE_CYC - 1);
            end
            nvm_prog_pkg::CMD_EE_WR: begin
              if (!pins.byte_sel_lo_hi) begin
                ee_we = 1'b1; // [RULE13]
                ee_wdata = ee_mem[ee_addr] & cur.data;
                next_cur.state = D_BYTE;
              end
            end
            nvm_prog_pkg::CMD_FUSE_WR: begin
              if (pins.byte_sel_lo_hi) begin
                next_cur.fuse_hi = cur.data |
                  nvm_prog_pkg::FUSE_HI_KEEP; // [RULE18]
              end else begin
                next_cur.fuse_lo = cur.data |
                  nvm_prog_pkg::FUSE_LO_KEEP; // [RULE17]
              end
              next_cur.state = D_BYTE;
            end
            nvm_prog_pkg::CMD_LOCK_WR: begin
              // AND keeps programmed bits programmed [RULE19] [RULE20]
              next_cur.lock = cur.lock &
                (cur.data | nvm_prog_pkg::LOCK_KEEP);
              next_cur.state = D_BYTE;
            end
            default: next_cur.state = D_IDLE;
          endcase
        end
      end
      D_ERASE, D_PAGE, D_BYTE: begin
        // One array word per cycle; the busy time covers the sweep
        if (!cur.sweep_done) begin
          if (cur.state == D_ERASE) begin
            fl_we = 1'b1; // [RULE3]
            ee_we = 1'b1;
            ee_waddr = cur.idx[8:0];
            next_cur.sweep_done = (cur.idx == nvm_prog_pkg::FLASH_LAST);
          end else begin
            // Programming only clears bits, hence erase first [RULE4]
            fl_we = 1'b1; // [RULE5]
            fl_waddr = pg_waddr;
            fl_wdata = flash_mem[pg_waddr] & page_buf[cur.idx[5:0]];
            pb_we = 1'b1;
            pb_idx = cur.idx[5:0];
            pb_wdata = nvm_prog_pkg::WORD_ERASED;
            next_cur.sweep_done = (cur.idx[5:0] == nvm_prog_pkg::PAGE_LAST);
          end
          next_cur.idx = cur.idx + 13'h0001;
        end
        if (cur.timer != 32'h0000_0000) begin
          next_cur.timer = cur.timer - 32'h0000_0001;
        end else if (cur.sweep_done) begin
          if (cur.state == D_ERASE) begin
            next_cur.lock = nvm_prog_pkg::LOCK_RESET; // [RULE3] [RULE20]
          end
          next_cur.state = D_IDLE;
        end
      end
      default: next_cur.state = D_IDLE;
    endcase
    next_cur.rdy = (next_cur.state == D_IDLE); // [RULE22]
    // Read path, registered so the pins come from flops
    next_cur.doe = cur.in_mode && !pins.out_enable_n; // [RULE23]
    case (cur.cmd)
      nvm_prog_pkg::CMD_FLASH_RD: begin
        next_cur.dout = pins.byte_sel_lo_hi ?
          flash_mem[rd_waddr][15:8] : flash_mem[rd_waddr][7:0]; // [RULE15]
      end
      nvm_prog_pkg::CMD_EE_RD: next_cur.dout = ee_mem[ee_addr]; // [RULE16]
      default: next_cur.dout = nvm_prog_pkg::BYTE_ERASED;
    endcase
  end
  // State register
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cur <= '0;
      cur.state <= D_IDLE;
      cur.prev_wr_n <= 1'b1;
      cur.cmd <= nvm_prog_pkg::CMD_NOP;
      cur.fuse_lo <= nvm_prog_pkg::FUSE_LO_RESET;
      cur.fuse_hi <= nvm_prog_pkg::FUSE_HI_RESET;
      cur.lock <= nvm_prog_pkg::LOCK_RESET;
      cur.sweep_done <= 1'b1;
      cur.rdy <= 1'b1;
      cur.dout <= nvm_prog_pkg::BYTE_ERASED;
    end else begin
      cur <= next_cur;
    end
  end
  // Array writes; flash and EEPROM contents are unknown until the first chip erase
  always_ff @(posedge clk_sys) begin
    if (fl_we) begin
      flash_mem[fl_waddr] <= fl_wdata;
    end
    if (ee_we) begin
      ee_mem[ee_waddr] <= ee_wdata;
    end
    if (pb_we) begin
      page_buf[pb_idx] <= pb_wdata;
    end
  end
  assign pins.dev_data = cur.dout;
  assign pins.dev_data_oe = cur.doe;
  assign pins.ready_busy_flag = cur.rdy;
  assign fuse_lo = cur.fuse_lo;
  assign fuse_hi = cur.fuse_hi;
  assign lock_bits = cur.lock;
  assign prog_mode_active = cur.in_mode;
endmodule

// ### nvm_prog_host.sv
// Programmer end: turns register-written steps into pin sequences
`timescale 1ns/100ps
module nvm_prog_host (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Programming pins
  nvm_prog_if.host pins,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [15:0] rdata
);

  typedef enum logic [4:0] {
    H_IDLE = 5'h01,
    H_SETUP = 5'h02,
    H_PULSE = 5'h04,
    H_HOLD = 5'h08,
    H_WAIT = 5'h10
  } host_state_e;

  typedef struct packed {
    host_state_e state;
    logic [2:0] op;
    logic [3:0] cnt;
    logic a1;
    logic a0;
    logic bs;
    logic latch;
    logic load;
    logic wr_n;
    logic oe_n;
    logic mode;
    logic [7:0] hdata;
    logic hoe;
    logic [7:0] rbyte;
    logic [15:0] rdata;
  } host_s;

  host_s cur;
  host_s next_cur;
  logic tick;

  // Phase divider: setup, pulse and hold each last one full pulse width; wait lasts until ready
  assign tick = (cur.cnt == 4'h0);

  always_comb begin
    next_cur = cur;
    next_cur.cnt = tick ? nvm_prog_pkg::PULSE_CYC - 4'h1 : cur.cnt - 4'h1;
    case (cur.state)
      H_IDLE: begin
        next_cur.cnt = nvm_prog_pkg::PULSE_CYC - 4'h1;
        // Steps are taken only while idle; others are dropped
        if (wr_en && addr == nvm_prog_pkg::REG_OP) begin
          next_cur.op = wdata[nvm_prog_pkg::OP_CODE_LSB +: 3];
          next_cur.bs = wdata[nvm_prog_pkg::OP_BS_BIT];
          next_cur.hdata = wdata[nvm_prog_pkg::OP_DATA_LSB +: 8];
          next_cur.state = H_SETUP;
          if (wdata[nvm_prog_pkg::OP_CODE_LSB +: 3] == nvm_prog_pkg::OP_LOAD)
          begin
            // Command, address or data byte set up on the bus [RULE6]
            {next_cur.a1, next_cur.a0} = wdata[nvm_prog_pkg::OP_ACT_LSB +: 2];
            next_cur.hoe = 1'b1; // [RULE2] [RULE12] [RULE17] [RULE19]
          end
          if (wdata[nvm_prog_pkg::OP_CODE_LSB +: 3] == nvm_prog_pkg::OP_ENTER)
          begin
            next_cur.bs = 1'b0; // [RULE21]
            next_cur.mode = 1'b0;
          end
          if (wdata[nvm_prog_pkg::OP_CODE_LSB +: 3] == nvm_prog_pkg::OP_EXIT)
          begin
            next_cur.mode = 1'b0;
            next_cur.state = H_IDLE;
          end
        end
      end
      H_SETUP: begin
        if (tick) begin
          next_cur.state = H_PULSE;
          case (cur.op)
            nvm_prog_pkg::OP_LOAD: next_cur.load = 1'b1;
            // Software repeats address, data and latch 64 times [RULE9]
            nvm_prog_pkg::OP_LATCH: next_cur.latch = 1'b1;
            nvm_prog_pkg::OP_PROG: next_cur.wr_n = 1'b0; // [RULE13]
            nvm_prog_pkg::OP_READ: next_cur.oe_n = 1'b0;
            nvm_prog_pkg::OP_ENTER: next_cur.mode = 1'b1; // [RULE21]
            default: next_cur.state = H_HOLD;
          endcase
        end
      end
      H_PULSE: begin
        if (tick) begin
          next_cur.state = H_HOLD;
          next_cur.load = 1'b0;
          next_cur.latch = 1'b0;
          next_cur.wr_n = 1'b1;
          next_cur.oe_n = 1'b1;
          if (cur.op == nvm_prog_pkg::OP_READ) begin
            next_cur.rbyte = pins.data_bus;
          end
        end
      end
      H_HOLD: begin
        // Byte select stays put for a full phase after entry [RULE21]
        if (tick) begin
          next_cur.hoe = 1'b0;
          {next_cur.a1, next_cur.a0} = nvm_prog_pkg::ACT_IDLE;
          next_cur.state = (cur.op == nvm_prog_pkg::OP_PROG) ?
                           H_WAIT : H_IDLE;
          if (cur.op != nvm_prog_pkg::OP_PROG) begin
            next_cur.bs = 1'b0;
          end
        end
      end
      H_WAIT: begin
        // Nothing new until the device reports ready [RULE4] [RULE11]
        if (pins.ready_busy_flag) begin
          next_cur.bs = 1'b0; // [RULE18]
          next_cur.state = H_IDLE;
        end
      end
      default: next_cur.state = H_IDLE;
    endcase
    // Register reads answer in the next cycle
    next_cur.rdata = 16'h0000;
    if (rd_en) begin
      case (addr)
        nvm_prog_pkg::REG_STATUS: begin
          next_cur.rdata[nvm_prog_pkg::ST_BUSY_BIT] = (cur.state != H_IDLE);
          next_cur.rdata[nvm_prog_pkg::ST_READY_BIT] = pins.ready_busy_flag;
          next_cur.rdata[nvm_prog_pkg::ST_MODE_BIT] = cur.mode;
        end
        nvm_prog_pkg::REG_RDATA: next_cur.rdata = {8'h00, cur.rbyte};
        default: next_cur.rdata = 16'h0000;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cur <= '0;
      cur.state <= H_IDLE;
      cur.a1 <= 1'b1;
      cur.a0 <= 1'b1;
      cur.wr_n <= 1'b1;
      cur.oe_n <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  assign pins.action_sel_1 = cur.a1;
  assign pins.action_sel_0 = cur.a0;
  assign pins.byte_sel_lo_hi = cur.bs;
  assign pins.byte_sel_ext = 1'b0;
  assign pins.buffer_latch_pulse = cur.latch;
  assign pins.load_strobe_pin = cur.load;
  assign pins.prog_strobe_n = cur.wr_n;
  assign pins.out_enable_n = cur.oe_n;
  assign pins.prog_voltage = cur.mode;
  assign pins.host_data = cur.hdata;
  assign pins.host_data_oe = cur.hoe;
  assign rdata = cur.rdata;

endmodule

// ### nvm_prog_props.sv
// Pin-level checker between programmer and device ends
`timescale 1ns/100ps
module nvm_prog_props (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Programmer pins
  input wire logic action_sel_1,
  input wire logic action_sel_0,
  input wire logic byte_sel_lo_hi,
  input wire logic byte_sel_ext,
  input wire logic buffer_latch_pulse,
  input wire logic load_strobe_pin,
  input wire logic prog_strobe_n,
  input wire logic out_enable_n,
  input wire logic prog_voltage,
  input wire logic host_data_oe,
  // Device pins
  input wire logic dev_data_oe,
  input wire logic ready_busy_flag
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  logic [13:0] busy_len;

  // Busy stretch length; a sweep longer than the erase means a hang
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      busy_len <= 14'h0000;
    end else begin
      busy_len <= ready_busy_flag ? 14'h0000 : busy_len + 14'h0001;
    end
  end

  // Bus ownership and control hold
  AST_OE_ONLY: assert property (dev_data_oe |->
    !$past(out_enable_n) || !$past(out_enable_n, 2))
    else $error("device drove bus without output enable");
  AST_NO_FIGHT: assert property (!(dev_data_oe && host_data_oe))
    else $error("both ends drive the data bus");
  AST_CTRL_HOLD: assert property (load_strobe_pin &&
    $past(load_strobe_pin) |->
    $stable({action_sel_1, action_sel_0, byte_sel_lo_hi}))
    else $error("action code moved during load strobe");
  AST_LATCH_HOLD: assert property (buffer_latch_pulse &&
    $past(buffer_latch_pulse) |-> $stable(byte_sel_lo_hi))
    else $error("byte select moved during latch pulse");
  AST_ENTRY_QUIET: assert property ($rose(prog_voltage) |->
    (!byte_sel_lo_hi && !byte_sel_ext) ##1 (!byte_sel_lo_hi) [*3])
    else $error("byte select active around mode entry");
  // Busy handshake
  AST_BUSY_CAUSE: assert property ($fell(ready_busy_flag) |->
    !$past(prog_strobe_n))
    else $error("busy without program strobe");
  AST_LOAD_IDLE: assert property ($rose(load_strobe_pin) |->
    ready_busy_flag)
    else $error("load strobe while device busy");
  AST_PROG_READY: assert property ($fell(prog_strobe_n) |->
    ready_busy_flag)
    else $error("program strobe while device busy");
  AST_BUSY_BOUND: assert property (busy_len <= 14'h206C)
    else $error("busy stretch too long");
  COV_BUSY: cover property ($fell(ready_busy_flag));
  COV_READ: cover property ($rose(dev_data_oe));
  COV_ENTRY: cover property ($rose(prog_voltage));
endmodule

// ### tb_parallel_nvm_programming_port.sv
// Bench joining programmer and device with random page traffic
`timescale 1ns/100ps
module tb_parallel_nvm_programming_port;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [15:0] rdata;
  logic [7:0] fuse_lo, fuse_hi, lock_bits, d0, d1;
  logic prog_mode_active;
  logic [15:0] page [64];
  logic [15:0] v;
  logic [6:0] pg;
  int bad_count = 0;
  int num_checks = 0;
  int cycles = 0;

  nvm_prog_if link ();
  nvm_prog_host nvm_prog_host_inst (.clk_sys(clk_sys), .resetn(resetn),
    .pins(link), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata));
  // Short busy lengths keep the run brief
  nvm_prog_device #(.ERASE_CYC(10), .PAGE_CYC(100), .BYTE_CYC(20))
    nvm_prog_device_inst (.clk_sys(clk_sys), .resetn(resetn),
    .pins(link), .fuse_lo(fuse_lo), .fuse_hi(fuse_hi),
    .lock_bits(lock_bits), .prog_mode_active(prog_mode_active));
  nvm_prog_props nvm_prog_props_inst (.clk_sys(clk_sys),
    .resetn(resetn), .action_sel_1(link.action_sel_1),
    .action_sel_0(link.action_sel_0),
    .byte_sel_lo_hi(link.byte_sel_lo_hi),
    .byte_sel_ext(link.byte_sel_ext),
    .buffer_latch_pulse(link.buffer_latch_pulse),
    .load_strobe_pin(link.load_strobe_pin),
    .prog_strobe_n(link.prog_strobe_n),
    .out_enable_n(link.out_enable_n),
    .prog_voltage(link.prog_voltage),
    .host_data_oe(link.host_data_oe), .dev_data_oe(link.dev_data_oe),
    .ready_busy_flag(link.ready_busy_flag));

  always #20 clk_sys = ~clk_sys;

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Cut a hang short; the whole run needs about 31000 cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 90000) begin
      bad_count++;
      wrap_up();
    end
  end

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Register port cycles; read data is taken in the cycle after the strobe
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask
  // One host step, then poll its busy bit under a bound
  task automatic step(input logic [2:0] op, input logic [1:0] act,
                      input logic bs, input logic [7:0] d);
    logic [15:0] s;
    wr(nvm_prog_pkg::REG_OP, {d, 1'b0, bs, act, 1'b0, op});
    s = 16'h0001;
    for (int i = 0; i < 6000 && s[0] !== 1'b0; i++)
      rd(nvm_prog_pkg::REG_STATUS, s);
    chk("step_busy", 8'h00, {7'h00, s[0]});
  endtask
  task automatic ld(input logic [1:0] act, input logic bs,
                    input logic [7:0] d);
    step(nvm_prog_pkg::OP_LOAD, act, bs, d);
  endtask
  task automatic prog(input logic bs);
    step(nvm_prog_pkg::OP_PROG, 2'h3, bs, 8'h00);
  endtask
  task automatic rdb(input logic bs, output logic [15:0] r);
    step(nvm_prog_pkg::OP_READ, 2'h3, bs, 8'h00);
    rd(nvm_prog_pkg::REG_RDATA, r);
  endtask
  // Programmed bits only fall; kept bits stay one
  function automatic logic [7:0] nv_next(input logic [7:0] old,
      input logic [7:0] d, input logic [7:0] keep);
    return old & (d | keep);
  endfunction

  initial begin
    void'($urandom(32'h1723));
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    step(nvm_prog_pkg::OP_ENTER, 2'h3, 1'b0, 8'h00);
    chk("mode", 8'h01, {7'h00, prog_mode_active});
    rd(nvm_prog_pkg::REG_STATUS, v);
    chk("status", 8'h06, v[7:0]);
    $display("test entry done");
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    ld(2'h2, 1'b0, nvm_prog_pkg::CMD_FUSE_WR);
    ld(2'h1, 1'b0, d0);
    prog(1'b0);
    chk("fuse_lo", d0 | nvm_prog_pkg::FUSE_LO_KEEP, fuse_lo);
    ld(2'h1, 1'b0, d1);
    prog(1'b1);
    chk("fuse_hi", d1 | nvm_prog_pkg::FUSE_HI_KEEP, fuse_hi);
    ld(2'h2, 1'b0, nvm_prog_pkg::CMD_LOCK_WR);
    ld(2'h1, 1'b0, d0);
    prog(1'b0);
    chk("lock", nv_next(8'hFF, d0, 8'hC0), lock_bits);
    ld(2'h1, 1'b0, 8'hFF);
    prog(1'b0);
    chk("lock", nv_next(8'hFF, d0, 8'hC0), lock_bits);
    ld(2'h2, 1'b0, nvm_prog_pkg::CMD_ERASE);
    prog(1'b0);
    chk("lock", 8'hFF, lock_bits);
    chk("fuse_lo", d0 | nvm_prog_pkg::FUSE_LO_KEEP, fuse_lo);
    $display("test fuse lock erase done");
    // Fill one random page, first word all zero, then read it back
    pg = 7'($urandom);
    ld(2'h2, 1'b0, nvm_prog_pkg::CMD_FLASH_WR);
    for (int w = 0; w < 64; w++) begin
      page[w] = (w == 0) ? 16'h0000 : 16'($urandom);
      ld(2'h0, 1'b0, {pg[1:0], 6'(w)});
      ld(2'h1, 1'b0, page[w][7:0]);
      step(nvm_prog_pkg::OP_LATCH, 2'h3, 1'b0, 8'h00);
      ld(2'h1, 1'b1, page[w][15:8]);
      step(nvm_prog_pkg::OP_LATCH, 2'h3, 1'b1, 8'h00);
    end
    ld(2'h0, 1'b1, {3'h0, pg[6:2]});
    prog(1'b0);
    ld(2'h2, 1'b0, nvm_prog_pkg::CMD_NOP);
    ld(2'h2, 1'b0, nvm_prog_pkg::CMD_FLASH_RD);
    for (int w = 0; w < 64; w++) begin
      ld(2'h0, 1'b0, {pg[1:0], 6'(w)});
      rdb(1'b0, v);
      chk("flash_lo", page[w][7:0], v[7:0]);
      rdb(1'b1, v);
      chk("flash_hi", page[w][15:8], v[7:0]);
    end
    $display("test flash page done");
    ld(2'h2, 1'b0, nvm_prog_pkg::CMD_EE_WR);
    ld(2'h0, 1'b1, {7'h00, pg[0]});
    ld(2'h0, 1'b0, d1);
    ld(2'h1, 1'b0, d0);
    prog(1'b0);
    ld(2'h2, 1'b0, nvm_prog_pkg::CMD_EE_RD);
    rdb(1'b0, v);
    chk("eeprom", d0, v[7:0]);
    $display("test eeprom done");
    step(nvm_prog_pkg::OP_EXIT, 2'h3, 1'b0, 8'h00);
    chk("mode", 8'h00, {7'h00, prog_mode_active});
    $display("test exit done");
    wrap_up();
  end
endmodule
